// File: rtl/wan_modem_control_sequencer.sv
// Notes on behaviour
// - Clear-to-send never paces transmission
// - Ring raises both DTR and RTS
// - Wait carrier_wait_time for CD and DSR
// - Leased mode: respond once CD is high
// - No CD in time: drop lines 5 s
// - Toggle polling repeats while link inactive
// - Ring while DTR low: raise, new wait
// - Protocol timeout starts the toggle cycle
// - Link up only with CD and DSR
// - CD absent 10 s while up: alarm
// - CD loss alone keeps link up
// - Ring while DTR high restarts wait timer
// - Ring ignored once link is up
// - Backup mode idle: hold lines low
// - Backup activation raises lines to call
`timescale 1ns/10ps
module wan_modem_control_sequencer #(
  parameter int unsigned TICK_CYCLES = modem_seq_pkg::CYCLES_PER_SEC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Register port
  input wire logic [modem_seq_pkg::ADDR_W-1:0] addr,
  input wire logic [modem_seq_pkg::DATA_W-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [modem_seq_pkg::DATA_W-1:0] rdata,
  // Modem side
  input wire modem_seq_pkg::modem_in_t modem_in,
  output logic dtr,
  output logic rts,
  // Link layer side
  input wire logic l2_timeout,
  output logic tx_permit,
  output logic carrier_alarm,
  // Interrupt
  output logic irq
);
  import modem_seq_pkg::*;

  // ****************************************
  // Input synchronisers
  // ****************************************
  modem_in_t in_meta;
  modem_in_t in_s;
  logic ri_prev;
  logic ri_rise;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      in_meta <= '0;
      in_s <= '0;
      ri_prev <= 1'b0;
    end else begin
      in_meta <= modem_in;
      in_s <= in_meta;
      ri_prev <= in_s.ri;
    end
  end

  assign ri_rise = in_s.ri && !ri_prev;

  // ****************************************
  // Registers
  // ****************************************
  ctrl_t ctrl;
  logic [SECS_W-1:0] wait_secs;
  logic [NUM_EV-1:0] int_stat;
  logic [NUM_EV-1:0] int_mask;
  logic [NUM_EV-1:0] events;
  logic hit_ctrl;
  logic hit_wait;
  logic hit_stat;
  logic hit_mask;

  assign hit_ctrl = addr == OFS_CTRL;
  assign hit_wait = addr == OFS_WAIT;
  assign hit_stat = addr == OFS_INT_STAT;
  assign hit_mask = addr == OFS_INT_MASK;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= CTRL_RESET;
      wait_secs <= CARRIER_WAIT_S;
      int_mask <= MASK_RESET;
    end else if (wr) begin
      if (hit_ctrl) begin
        ctrl <= ctrl_t'(wdata[CTRL_W-1:0]);
      end
      if (hit_wait) begin
        wait_secs <= wdata[SECS_W-1:0];
      end
      if (hit_mask) begin
        int_mask <= wdata[NUM_EV-1:0];
      end
    end
  end

  // New events win over a write-one-to-clear in the same cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      int_stat <= '0;
    end else if (wr && hit_stat) begin
      int_stat <= (int_stat & ~wdata[NUM_EV-1:0]) | events;
    end else begin
      int_stat <= int_stat | events;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(int_stat & int_mask);
    end
  end

  // ****************************************
  // Sequencer
  // ****************************************
  seq_state_t state;
  seq_state_t next_state;
  logic [SECS_W-1:0] secs;
  logic tick;
  logic restart;
  logic hold_off;
  logic expire;
  logic drop_done;
  logic loss_hit;
  logic [1:0] state_code;

  assign hold_off = ctrl.backup && !ctrl.activate;
  assign expire = tick && ({1'b0, secs} + 9'h001 >= {1'b0, wait_secs});
  assign drop_done = tick && (secs == TOGGLE_S - 8'h01);
  assign loss_hit = (state == S_UP) && tick && !in_s.cd && (secs == LOSS_S - 8'h01);

  always_comb begin
    next_state = state;
    if (hold_off) begin
      next_state = S_IDLE;
    end else if (l2_timeout) begin
      next_state = S_DROP;
    end else begin
      unique case (state)
        S_IDLE: begin
          if (ctrl.backup && ctrl.activate) begin
            next_state = S_WAIT;
          end else if (ctrl.leased ? in_s.cd : ri_rise) begin
            next_state = S_WAIT;
          end
        end
        S_WAIT: begin
          if (in_s.cd && in_s.dsr) begin
            next_state = S_UP;
          end else if (!ri_rise && expire && !in_s.cd) begin
            next_state = S_DROP;
          end
        end
        S_DROP: begin
          if (ri_rise || drop_done) begin
            next_state = S_WAIT;
          end
        end
        S_UP: begin
          next_state = S_UP;
        end
      endcase
    end
  end

  // Timer restarts on every state change, on a ring while waiting, and
  // whenever carrier is present on a live link
  assign restart = (next_state != state)
                 || (state == S_WAIT && ri_rise)
                 || (state == S_UP && in_s.cd);

  tick_divider #(
    .CYCLES(TICK_CYCLES)
  ) u_tick (
    .clk(clk),
    .rst_n(rst_n),
    .clear(restart),
    .tick(tick)
  );

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= S_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Saturating seconds count; stops one alarm from repeating
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      secs <= '0;
    end else if (restart) begin
      secs <= '0;
    end else if (tick && secs != 8'hff && !(state == S_UP && secs == LOSS_S)) begin
      secs <= secs + 8'h01;
    end
  end

  // DTR and RTS always move together
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dtr <= 1'b0;
      rts <= 1'b0;
    end else begin
      dtr <= (next_state == S_WAIT) || (next_state == S_UP);
      rts <= (next_state == S_WAIT) || (next_state == S_UP);
    end
  end

  // Clear-to-send is not an input: transmit permission depends on link state
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_permit <= 1'b0;
    end else begin
      tx_permit <= next_state == S_UP;
    end
  end

  // Alarm stays while carrier is still away on a live link
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      carrier_alarm <= 1'b0;
    end else if (loss_hit) begin
      carrier_alarm <= 1'b1;
    end else if (in_s.cd || next_state != S_UP) begin
      carrier_alarm <= 1'b0;
    end
  end

  always_comb begin
    events = '0;
    events[EV_UP] = (state != S_UP) && (next_state == S_UP);
    events[EV_LOSS] = loss_hit;
    events[EV_EXPIRE] = (state == S_WAIT) && (next_state == S_DROP);
    events[EV_RING] = ri_rise && (state != S_UP);
  end

  // ****************************************
  // Read port
  // ****************************************
  always_comb begin
    unique case (state)
      S_IDLE: state_code = 2'h0;
      S_WAIT: state_code = 2'h1;
      S_DROP: state_code = 2'h2;
      S_UP: state_code = 2'h3;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= '0;
    end else if (rd) begin
      rdata <= '0;
      unique case (addr)
        OFS_CTRL: rdata[CTRL_W-1:0] <= ctrl;
        OFS_WAIT: rdata[SECS_W-1:0] <= wait_secs;
        OFS_STATUS: begin
          rdata[ST_DTR] <= dtr;
          rdata[ST_UP] <= tx_permit;
          rdata[ST_ALARM] <= carrier_alarm;
          rdata[ST_RI] <= in_s.ri;
          rdata[ST_CD] <= in_s.cd;
          rdata[ST_DSR] <= in_s.dsr;
          rdata[ST_STATE_LO +: 2] <= state_code;
          rdata[ST_SECS_LO +: SECS_W] <= secs;
        end
        OFS_INT_STAT: rdata[NUM_EV-1:0] <= int_stat;
        OFS_INT_MASK: rdata[NUM_EV-1:0] <= int_mask;
        default: rdata <= '0;
      endcase
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  AST_LINES_PAIRED: assert property (@(posedge clk) disable iff (!rst_n)
    dtr == rts)
    else $error("DTR and RTS differ");

  AST_RING_RAISES: assert property (@(posedge clk) disable iff (!rst_n)
    state == S_IDLE && ri_rise && !ctrl.backup && !ctrl.leased && !l2_timeout
    |=> dtr && rts && state == S_WAIT)
    else $error("Ring did not raise DTR and RTS");

  AST_LEASED_CD: assert property (@(posedge clk) disable iff (!rst_n)
    state == S_IDLE && ctrl.leased && in_s.cd && !hold_off && !l2_timeout
    |=> dtr)
    else $error("Leased mode did not respond to carrier");

  AST_WAIT_EXPIRES: assert property (@(posedge clk) disable iff (!rst_n)
    state == S_WAIT && expire && !in_s.cd && !ri_rise && !hold_off && !l2_timeout
    |=> state == S_DROP && !dtr && secs == 8'h00)
    else $error("Carrier wait expiry did not drop lines");

  AST_DROP_LENGTH: assert property (@(posedge clk) disable iff (!rst_n)
    state == S_DROP && tick && secs == TOGGLE_S - 8'h01 && !hold_off && !l2_timeout
    |=> state == S_WAIT && dtr)
    else $error("Drop period did not end in a new wait");

  AST_RING_IN_DROP: assert property (@(posedge clk) disable iff (!rst_n)
    state == S_DROP && ri_rise && !hold_off && !l2_timeout
    |=> dtr && secs == 8'h00)
    else $error("Ring during drop did not raise lines");

  AST_L2_TOGGLE: assert property (@(posedge clk) disable iff (!rst_n)
    l2_timeout && !hold_off |=> state == S_DROP && !dtr)
    else $error("Protocol timeout did not start toggling");

  AST_UP_NEEDS_BOTH: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(tx_permit) |-> $past(in_s.cd) && $past(in_s.dsr))
    else $error("Link came up without CD and DSR");

  AST_LOSS_ALARM: assert property (@(posedge clk) disable iff (!rst_n)
    loss_hit |=> carrier_alarm && int_stat[EV_LOSS])
    else $error("Carrier loss alarm missing");

  AST_STAY_UP: assert property (@(posedge clk) disable iff (!rst_n)
    state == S_UP && !hold_off && !l2_timeout |=> state == S_UP [*1] ##0 tx_permit)
    else $error("Link dropped without protocol timeout");

  AST_RING_RESTART: assert property (@(posedge clk) disable iff (!rst_n)
    state == S_WAIT && ri_rise && !(in_s.cd && in_s.dsr) && !hold_off && !l2_timeout
    |=> secs == 8'h00 && state == S_WAIT)
    else $error("Ring did not restart carrier wait");

  AST_RI_IGNORED_UP: assert property (@(posedge clk) disable iff (!rst_n)
    state == S_UP && ri_rise && !hold_off && !l2_timeout
    |=> state == S_UP ##1 (state == S_UP || $past(l2_timeout) || $past(hold_off)))
    else $error("Ring disturbed a live link");

  AST_BACKUP_LOW: assert property (@(posedge clk) disable iff (!rst_n)
    hold_off |=> !dtr && !rts && !tx_permit)
    else $error("Backup link not held idle");

  AST_BACKUP_CALL: assert property (@(posedge clk) disable iff (!rst_n)
    state == S_IDLE && ctrl.backup && ctrl.activate && !l2_timeout |=> dtr && rts)
    else $error("Backup activation did not raise lines");

  COV_RING_UP: cover property (@(posedge clk) disable iff (!rst_n)
    state == S_WAIT ##[1:20] state == S_UP);
  COV_EXPIRE: cover property (@(posedge clk) disable iff (!rst_n)
    state == S_WAIT ##1 state == S_DROP);
  COV_REDIAL: cover property (@(posedge clk) disable iff (!rst_n)
    state == S_DROP ##1 state == S_WAIT);
  COV_ALARM: cover property (@(posedge clk) disable iff (!rst_n) $rose(carrier_alarm));

endmodule : wan_modem_control_sequencer

// File: rtl/modem_seq_pkg.sv
package modem_seq_pkg;

  // ****************************************
  // Bus geometry
  // ****************************************
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // ****************************************
  // Register offsets (byte addresses)
  // ****************************************
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_WAIT = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_INT_STAT = 8'h0c;
  localparam logic [7:0] OFS_INT_MASK = 8'h10;

  // ****************************************
  // Field layouts and reset values
  // ****************************************
  localparam int CTRL_W = 3;
  localparam int NUM_EV = 4;
  localparam int EV_UP = 0;
  localparam int EV_LOSS = 1;
  localparam int EV_EXPIRE = 2;
  localparam int EV_RING = 3;
  localparam int ST_DTR = 0;
  localparam int ST_UP = 1;
  localparam int ST_ALARM = 2;
  localparam int ST_RI = 3;
  localparam int ST_CD = 4;
  localparam int ST_DSR = 5;
  localparam int ST_STATE_LO = 6;
  localparam int ST_SECS_LO = 8;
  localparam logic [2:0] CTRL_RESET = 3'h0;
  localparam logic [3:0] MASK_RESET = 4'h0;

  // ****************************************
  // Timing
  // ****************************************
  localparam int SECS_W = 8;
  localparam logic [7:0] CARRIER_WAIT_S = 8'h3c;
  localparam logic [7:0] TOGGLE_S = 8'h05;
  localparam logic [7:0] LOSS_S = 8'h0a;
  localparam int unsigned SEC_NS = 1000000000;
  localparam int unsigned CLK_PERIOD_NS = 25;
  localparam int unsigned CYCLES_PER_SEC = SEC_NS / CLK_PERIOD_NS;
  localparam int DIV_W = 26;

  // ****************************************
  // Types
  // ****************************************
  typedef struct packed {
    logic ri;
    logic cd;
    logic dsr;
  } modem_in_t;

  typedef struct packed {
    logic activate;
    logic backup;
    logic leased;
  } ctrl_t;

  typedef enum logic [1:0] {
    S_IDLE,
    S_WAIT,
    S_DROP,
    S_UP
  } seq_state_t;

endpackage : modem_seq_pkg

// File: rtl/tick_divider.sv
`timescale 1ns/10ps
module tick_divider #(
  parameter int unsigned CYCLES = modem_seq_pkg::CYCLES_PER_SEC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Control
  input wire logic clear,
  output logic tick
);
  import modem_seq_pkg::*;

  logic [DIV_W-1:0] cnt;

  // Restart keeps each interval aligned to its own start
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= '0;
      tick <= 1'b0;
    end else if (clear) begin
      cnt <= '0;
      tick <= 1'b0;
    end else if (cnt == DIV_W'(CYCLES - 1)) begin
      cnt <= '0;
      tick <= 1'b1;
    end else begin
      cnt <= cnt + 1'b1;
      tick <= 1'b0;
    end
  end

endmodule : tick_divider

// File: test/modem_model.sv
`timescale 1ns/10ps
module modem_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Terminal lines
  input wire logic dtr,
  input wire logic rts,
  // Scenario controls
  input wire logic ring_req,
  input wire logic answer_en,
  input wire logic dsr_en,
  input wire logic cut,
  input wire logic leased,
  input wire logic [3:0] answer_dly,
  // Lines towards the terminal
  output modem_seq_pkg::modem_in_t sig
);
  import modem_seq_pkg::*;

  logic [3:0] cnt;
  logic answered;

  // ****************************************
  // Call handling
  // ****************************************
  // Call drops while the lines are low; a new raise redials
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 4'h0;
      answered <= 1'b0;
    end else if (!(dtr && rts)) begin
      cnt <= 4'h0;
      answered <= 1'b0;
    end else if (answer_en && cnt == answer_dly) begin
      answered <= 1'b1;
    end else if (answer_en) begin
      cnt <= cnt + 4'h1;
    end
  end

  // Leased line: no ring, carrier independent of the lines
  assign sig = modem_in_t'({ring_req && !leased, (answered || leased) && !cut,
                            (answered || leased) && dsr_en});
endmodule : modem_model

// File: test/tb_top.sv
`timescale 1ns/10ps
module tb_top;
  import modem_seq_pkg::*;

  // ****************************************
  // Signals
  // ****************************************
  localparam int TK = 10;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic rd_d = 1'b0;
  logic l2_timeout = 1'b0;
  logic ring_req = 1'b0;
  logic answer_en = 1'b0;
  logic dsr_en = 1'b0;
  logic cut = 1'b0;
  logic leased = 1'b0;
  logic [3:0] answer_dly = 4'h0;
  logic [31:0] rdata;
  modem_in_t modem_in;
  logic dtr, rts, tx_permit, carrier_alarm, irq;
  int error_cnt = 0;
  int checks_done = 0;
  int n;
  int w;
  logic [31:0] exp_q[$];

  always #12.5 clk = ~clk;

  wan_modem_control_sequencer #(.TICK_CYCLES(TK)) wan_modem_control_sequencer_inst (
    .clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .modem_in(modem_in), .dtr(dtr), .rts(rts),
    .l2_timeout(l2_timeout), .tx_permit(tx_permit),
    .carrier_alarm(carrier_alarm), .irq(irq));

  modem_model modem_model_inst (
    .clk(clk), .rst_n(rst_n), .dtr(dtr), .rts(rts), .ring_req(ring_req),
    .answer_en(answer_en), .dsr_en(dsr_en), .cut(cut), .leased(leased),
    .answer_dly(answer_dly), .sig(modem_in));

  // ****************************************
  // Checking
  // ****************************************
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : end_of_test

  // Read data are checked only in the cycle after the strobe
  always @(posedge clk) rd_d <= rd;
  always @(negedge clk) begin
    if (rd_d) begin
      chk("rdata", rdata, exp_q.pop_front());
    end
  end

  function automatic logic pick(input int s);
    case (s)
      0: return dtr;
      1: return tx_permit;
      2: return carrier_alarm;
      default: return irq;
    endcase
  endfunction : pick

  // ****************************************
  // Drivers
  // ****************************************
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask : wr_reg

  task automatic rd_reg(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
  endtask : rd_reg

  // Sampled on the falling edge, away from the design's updates
  task automatic wait_on(input int s, input logic v, input int lim);
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (pick(s) !== v && n < lim);
    @(posedge clk);
    if (pick(s) !== v) begin
      error_cnt++;
      $display("unexpected wait on signal %0d: expected %0b seen %0b", s, v, pick(s));
      end_of_test();
    end
  endtask : wait_on

  task automatic stays(input int s, input logic v, input int cyc);
    repeat (cyc) begin
      @(negedge clk);
      chk("steady", pick(s), v);
    end
    @(posedge clk);
  endtask : stays

  task automatic rng(input string what, input int lo, input int hi);
    chk(what, (n >= lo && n <= hi), 1);
  endtask : rng

  task automatic ring();
    ring_req <= 1'b1;
    repeat (3) @(posedge clk);
    ring_req <= 1'b0;
    repeat (3) @(posedge clk);
  endtask : ring

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    void'($urandom(92));
    rd_reg(OFS_CTRL, 32'h0);
    rd_reg(OFS_WAIT, 32'h3c);
    rd_reg(OFS_STATUS, 32'h0);
    rd_reg(OFS_INT_MASK, 32'h0);
    rd_reg(8'h14, 32'h0);
    $display("test reset done");
    w = 2 + $urandom % 3;
    wr_reg(OFS_WAIT, w);
    wr_reg(OFS_INT_MASK, 32'h4);
    ring();
    wait_on(0, 1'b1, 4);
    chk("rts", rts, 1);
    wait_on(0, 1'b0, w * TK + 2 * TK);
    rng("wait_len", w * TK - 8, w * TK + 4);
    @(negedge clk);
    chk("irq", irq, 1);
    @(posedge clk);
    wait_on(0, 1'b1, 7 * TK);
    rng("drop_len", 5 * TK - 2, 5 * TK + 6);
    wr_reg(OFS_INT_STAT, 32'hf);
    rd_reg(OFS_INT_STAT, 32'h0);
    chk("irq", irq, 0);
    $display("test timeout cycle done");
    repeat (w * TK - 8) @(posedge clk);
    ring();
    wait_on(0, 1'b0, w * TK + 2 * TK);
    rng("restart_len", w * TK - 10, w * TK + 6);
    repeat (TK) @(posedge clk);
    ring();
    wait_on(0, 1'b1, 2);
    $display("test ring restart done");
    answer_dly <= $urandom % 8;
    answer_en <= 1'b1;
    stays(1, 1'b0, w * TK + 2 * TK);
    chk("dtr", dtr, 1);
    dsr_en <= 1'b1;
    wait_on(1, 1'b1, 6);
    ring();
    chk("tx_permit", tx_permit, 1);
    $display("test answer done");
    cut <= 1'b1;
    stays(2, 1'b0, 5 * TK);
    cut <= 1'b0;
    repeat (4) @(posedge clk);
    cut <= 1'b1;
    wait_on(2, 1'b1, 11 * TK + 6);
    rng("loss_len", 10 * TK - 2, 10 * TK + 8);
    chk("tx_permit", tx_permit, 1);
    cut <= 1'b0;
    wait_on(2, 1'b0, 6);
    $display("test carrier loss done");
    l2_timeout <= 1'b1;
    @(posedge clk);
    l2_timeout <= 1'b0;
    wait_on(0, 1'b0, 4);
    chk("tx_permit", tx_permit, 0);
    $display("test protocol timeout done");
    wr_reg(OFS_CTRL, 32'h2);
    wait_on(0, 1'b0, 8 * TK);
    ring();
    stays(0, 1'b0, 3 * TK);
    wr_reg(OFS_CTRL, 32'h6);
    wait_on(0, 1'b1, 6);
    $display("test backup done");
    wr_reg(OFS_CTRL, 32'h2);
    wait_on(0, 1'b0, 4);
    answer_en <= 1'b0;
    leased <= 1'b1;
    wr_reg(OFS_CTRL, 32'h1);
    rd_reg(OFS_CTRL, 32'h1);
    wait_on(0, 1'b1, 6);
    wait_on(1, 1'b1, 6);
    $display("test leased done");
    end_of_test();
  end
endmodule : tb_top
